// >>> dcp_defines.vh
// Constants for the discharge current protection configuration block
// How it works
// RULE1: At a full reset the overcurrent threshold register is loaded from the stored threshold parameter and holds it until the next reset.
// RULE2: With sense range clear the threshold code selects 50 mV plus 10 mV per step, up to 200 mV.
// RULE3: With sense range set the threshold code selects 25 mV plus 5 mV per step, up to 100 mV.
// RULE4: At a full reset the overcurrent delay register is loaded from the stored delay parameter and holds it until the next reset.
// RULE5: The delay code in bits 3:0 selects 1 ms plus 2 ms per step, and bits 7:4 are unused.
// RULE6: At a full reset the short-circuit register is loaded from the stored short-circuit parameter.
// RULE7: The short-circuit delay code in bits 7:4 selects 61 us per step from zero, and bit 3 is unused.
// RULE8: The doubling bit doubles the selected short-circuit delay.
// RULE9: With sense range clear the short-circuit threshold code selects 100 mV plus 50 mV per step.
// RULE10: With sense range set the short-circuit threshold code selects 50 mV plus 25 mV per step.
// RULE11: The three configuration registers read zero from power-on reset until loaded.
// RULE12: A fault is raised only when the sense voltage stays above threshold for the whole delay.
`ifndef DCP_DEFINES_VH
`define DCP_DEFINES_VH
`define DCP_ADDR_OC_THR    8'h00
`define DCP_ADDR_OC_DLY    8'h04
`define DCP_ADDR_SC_CFG    8'h08
`define DCP_ADDR_STATE     8'h0C
`define DCP_ADDR_PARAM     8'h10
`define DCP_ADDR_STATUS    8'h14
`define DCP_ADDR_MASK      8'h18
`define DCP_ADDR_SENSE     8'h1C
`define DCP_CFG_RESET      8'h00
`define DCP_OC_THR_BASE0   16'd50
`define DCP_OC_THR_STEP0   16'd10
`define DCP_OC_THR_BASE1   16'd25
`define DCP_OC_THR_STEP1   16'd5
`define DCP_SC_THR_BASE0   16'd100
`define DCP_SC_THR_STEP0   16'd50
`define DCP_SC_THR_BASE1   16'd50
`define DCP_SC_THR_STEP1   16'd25
`define DCP_CLK_MHZ        100
`define DCP_OC_DLY_BASE_MS 5'h01
`define DCP_OC_DLY_STEP_MS 5'h02
`define DCP_SC_DLY_STEP_US 61
`define DCP_RESP_OKAY      2'b00
`define DCP_RESP_SLVERR    2'b10
`endif

// >>> dcp_protect.v
// Discharge overcurrent and short-circuit configuration with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "dcp_defines.vh"
module dcp_protect #(
  parameter [31:0] OC_MS_CYCLES = `DCP_CLK_MHZ * 1000,
  parameter [31:0] SC_US_CYCLES = `DCP_CLK_MHZ
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  overcurrent_threshold_param,
  input  wire [7:0]  overcurrent_delay_param,
  input  wire [7:0]  short_circuit_discharge_param,
  input  wire [15:0] sense_mv,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         oc_fault,
  output reg         sc_fault,
  output reg         irq
);
  reg  [7:0]  overcurrent_threshold_cfg_reg;
  reg  [7:0]  overcurrent_delay_cfg_reg;
  reg  [7:0]  short_circuit_discharge_cfg_reg;
  reg  [1:0]  state_control_reg;
  reg         loaded_reg;
  reg  [1:0]  status_reg;
  reg  [1:0]  mask_reg;
  reg  [15:0] sense_meta_reg;
  reg  [15:0] sense_sync_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_have_reg;
  reg         w_have_reg;
  reg  [31:0] oc_tick_reg;
  reg  [4:0]  oc_ms_reg;
  reg  [31:0] sc_tick_reg;
  reg  [10:0] sc_us_reg;
  wire        sense_range_select = state_control_reg[0];
  wire        sc_delay_doubling  = state_control_reg[1];
  wire [3:0]  overcurrent_threshold_code  = overcurrent_threshold_cfg_reg[3:0];
  wire [3:0]  overcurrent_delay_code      = overcurrent_delay_cfg_reg[3:0];
  wire [3:0]  short_circuit_delay_code    = short_circuit_discharge_cfg_reg[7:4];
  wire [2:0]  short_circuit_threshold_code = short_circuit_discharge_cfg_reg[2:0];
  reg  [15:0] oc_thr_mv;
  reg  [15:0] sc_thr_mv;
  wire [4:0]  oc_dly_ms;
  wire [10:0] sc_dly_us;
  wire [9:0]  sc_base_us;
  wire        oc_over;
  wire        sc_over;
  wire        do_write;
  wire        rd_status;
  reg  [31:0] rdata_next;
  reg  [1:0]  rresp_next;

  ////////////////////////////////////////////////////////////////////////////
  // Threshold and delay decode
  always @* begin
    if (sense_range_select) begin
      oc_thr_mv = `DCP_OC_THR_BASE1 + `DCP_OC_THR_STEP1 * {12'h000, overcurrent_threshold_code}; // RULE3
      sc_thr_mv = `DCP_SC_THR_BASE1 + `DCP_SC_THR_STEP1 * {13'h0000, short_circuit_threshold_code}; // RULE10
    end else begin
      oc_thr_mv = `DCP_OC_THR_BASE0 + `DCP_OC_THR_STEP0 * {12'h000, overcurrent_threshold_code}; // RULE2
      sc_thr_mv = `DCP_SC_THR_BASE0 + `DCP_SC_THR_STEP0 * {13'h0000, short_circuit_threshold_code}; // RULE9
    end
  end
  assign oc_dly_ms = `DCP_OC_DLY_BASE_MS + `DCP_OC_DLY_STEP_MS * {1'b0, overcurrent_delay_code}; // RULE5
  // Product is widened first: fifteen steps of 61 need ten bits
  assign sc_base_us = {6'h00, short_circuit_delay_code} * 10'h03D; // RULE7
  // Doubling is a shift so no second multiplier is needed
  assign sc_dly_us = sc_delay_doubling ?
                     {sc_base_us, 1'b0} :                                 // RULE8
                     {1'b0, sc_base_us};                                  // RULE7
  assign oc_over = sense_sync_reg > oc_thr_mv;
  assign sc_over = sense_sync_reg > sc_thr_mv;

  ////////////////////////////////////////////////////////////////////////////
  // Sense input synchroniser; a multi-bit sample may glitch for one cycle,
  // which the qualifying delay absorbs unless the short-circuit delay code is zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta_reg <= 16'h0000;
      sense_sync_reg <= 16'h0000;
    end else begin
      sense_meta_reg <= sense_mv;
      sense_sync_reg <= sense_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration load: parameters are caught once after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_threshold_cfg_reg   <= `DCP_CFG_RESET; // RULE11
      overcurrent_delay_cfg_reg       <= `DCP_CFG_RESET; // RULE11
      short_circuit_discharge_cfg_reg <= `DCP_CFG_RESET; // RULE11
      loaded_reg                      <= 1'b0;
    end else if (!loaded_reg) begin
      overcurrent_threshold_cfg_reg   <= {4'h0, overcurrent_threshold_param[3:0]}; // RULE1
      overcurrent_delay_cfg_reg       <= {4'h0, overcurrent_delay_param[3:0]};     // RULE4
      short_circuit_discharge_cfg_reg <= {short_circuit_discharge_param[7:4], 1'b0,
                                          short_circuit_discharge_param[2:0]};     // RULE6
      loaded_reg                      <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip timers: any dip below threshold restarts the count
  always @(posedge aclk) begin
    if (!aresetn || !loaded_reg || !oc_over) begin
      oc_tick_reg <= 32'h0000_0000; // RULE12
      oc_ms_reg   <= 5'h00;
      oc_fault    <= 1'b0;
    end else if (oc_ms_reg >= oc_dly_ms) begin
      oc_fault    <= 1'b1; // RULE12
    end else if (oc_tick_reg == OC_MS_CYCLES - 32'h0000_0001) begin
      oc_tick_reg <= 32'h0000_0000;
      oc_ms_reg   <= oc_ms_reg + 5'h01;
    end else begin
      oc_tick_reg <= oc_tick_reg + 32'h0000_0001;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || !loaded_reg || !sc_over) begin
      sc_tick_reg <= 32'h0000_0000; // RULE12
      sc_us_reg   <= 11'h000;
      sc_fault    <= 1'b0;
    end else if (sc_us_reg >= sc_dly_us) begin
      sc_fault    <= 1'b1; // RULE12
    end else if (sc_tick_reg == SC_US_CYCLES - 32'h0000_0001) begin
      sc_tick_reg <= 32'h0000_0000;
      sc_us_reg   <= sc_us_reg + 11'h001;
    end else begin
      sc_tick_reg <= sc_tick_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `DCP_RESP_OKAY;
      aw_have_reg       <= 1'b0;
      w_have_reg        <= 1'b0;
      awaddr_reg        <= 8'h00;
      wdata_reg         <= 32'h0000_0000;
      wstrb_reg         <= 4'h0;
      state_control_reg <= 2'b00;
      mask_reg          <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DCP_RESP_OKAY;
        if (awaddr_reg == `DCP_ADDR_STATE) begin
          if (wstrb_reg[0]) begin
            state_control_reg <= wdata_reg[1:0];
          end
        end else if (awaddr_reg == `DCP_ADDR_MASK) begin
          if (wstrb_reg[0]) begin
            mask_reg <= wdata_reg[1:0];
          end
        end else if (awaddr_reg == `DCP_ADDR_OC_THR || awaddr_reg == `DCP_ADDR_OC_DLY ||
                     awaddr_reg == `DCP_ADDR_SC_CFG || awaddr_reg == `DCP_ADDR_PARAM ||
                     awaddr_reg == `DCP_ADDR_STATUS || awaddr_reg == `DCP_ADDR_SENSE) begin
          // Loaded values change only through reset, so writes are dropped
          s_axi_bresp <= `DCP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `DCP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always @* begin
    rresp_next = `DCP_RESP_OKAY;
    if (s_axi_araddr == `DCP_ADDR_OC_THR) begin
      rdata_next = {24'h00_0000, overcurrent_threshold_cfg_reg};
    end else if (s_axi_araddr == `DCP_ADDR_OC_DLY) begin
      rdata_next = {24'h00_0000, overcurrent_delay_cfg_reg};
    end else if (s_axi_araddr == `DCP_ADDR_SC_CFG) begin
      rdata_next = {24'h00_0000, short_circuit_discharge_cfg_reg};
    end else if (s_axi_araddr == `DCP_ADDR_STATE) begin
      rdata_next = {30'h0000_0000, state_control_reg};
    end else if (s_axi_araddr == `DCP_ADDR_PARAM) begin
      rdata_next = {5'h00, sc_dly_us, 11'h000, oc_dly_ms};
    end else if (s_axi_araddr == `DCP_ADDR_STATUS) begin
      rdata_next = {28'h000_0000, sc_fault, oc_fault, status_reg};
    end else if (s_axi_araddr == `DCP_ADDR_MASK) begin
      rdata_next = {30'h0000_0000, mask_reg};
    end else if (s_axi_araddr == `DCP_ADDR_SENSE) begin
      rdata_next = {sc_thr_mv, oc_thr_mv};
    end else begin
      rdata_next = 32'h0000_0000;
      rresp_next = `DCP_RESP_SLVERR;
    end
  end
  assign rd_status = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `DCP_ADDR_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DCP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_next;
        s_axi_rresp  <= rresp_next;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky fault events, cleared by reading status; a new trip wins the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 2'b00;
      irq        <= 1'b0;
    end else begin
      status_reg <= (rd_status ? 2'b00 : status_reg) | {sc_over && sc_us_reg >= sc_dly_us && loaded_reg && !sc_fault,
                                                         oc_over && oc_ms_reg >= oc_dly_ms && loaded_reg && !oc_fault};
      irq        <= |(status_reg & mask_reg);
    end
  end
endmodule // dcp_protect
`default_nettype wire

// >>> dcp_protect_monitor.sv
// Port-level assertions for the discharge protection block
`timescale 1ns/1ps
`default_nettype none
module dcp_protect_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] sense_mv,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        oc_fault,
  input wire logic        sc_fault,
  input wire logic        irq
);
  // Sync stages delay the sense input, so a fault may trail it by a few cycles
  logic [5:0] oc_hist;
  logic [5:0] sc_hist;
  always @(posedge aclk) begin
    oc_hist <= {oc_hist[4:0], sense_mv >= 16'h0019};
    sc_hist <= {sc_hist[4:0], sense_mv >= 16'h0032};
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  property p_reset_clear;
    disable iff (1'b0)
    !aresetn |=> !oc_fault && !sc_fault && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not clear after reset");
  property p_oc_quiet;
    (sense_mv < 16'h0019)[*6] |=> !oc_fault;
  endproperty
  a_oc_quiet: assert property (p_oc_quiet)
    else $error("overcurrent fault below every threshold");
  property p_sc_quiet;
    (sense_mv < 16'h0032)[*6] |=> !sc_fault;
  endproperty
  a_sc_quiet: assert property (p_sc_quiet)
    else $error("short circuit fault below every threshold");
  property p_oc_cause;
    $rose(oc_fault) |-> |oc_hist;
  endproperty
  a_oc_cause: assert property (p_oc_cause)
    else $error("overcurrent fault without high sense");
  property p_sc_cause;
    $rose(sc_fault) |-> |sc_hist;
  endproperty
  a_sc_cause: assert property (p_sc_cause)
    else $error("short circuit fault without high sense");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response missing");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse)
    else $error("arready longer than one cycle");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  property p_r_err;
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_r_err: assert property (p_r_err)
    else $error("error read with nonzero data");
endmodule // dcp_protect_monitor
`default_nettype wire

// >>> dcp_sense_model.sv
// Differential sense voltage source feeding the protection block
`timescale 1ns/1ps
`default_nettype none
module dcp_sense_model (
  input  wire logic        aclk,
  input  wire logic [15:0] level_mv,
  output var  logic [15:0] sense_mv
);
  // Analog input moves off the clock edge, so the block must synchronise it
  initial sense_mv = 16'h0000;
  always @(posedge aclk) sense_mv <= #3 level_mv;
endmodule // dcp_sense_model
`default_nettype wire

// >>> test_discharge_current_protection_cfg.sv
// Self-checking bench for the discharge protection configuration block
`timescale 1ns/1ps
`default_nettype none
module test_discharge_current_protection_cfg;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0]  p_thr = 0, p_dly = 0, p_sc = 0, awaddr = 0, araddr = 0;
  logic [15:0] lvl = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0]  rs;
  wire  [15:0] sense_mv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         awready, wready, bvalid, arready, rvalid, oc_fault, sc_fault, irq;
  int          miscompares = 0, n_tests = 0, i, k, e_oc, e_sc, e_om, e_su;
  logic [7:0]  t_thr [4] = '{8'h0F, 8'h00, 8'hA5, 8'h00};
  logic [7:0]  t_dly [4] = '{8'h00, 8'h0F, 8'hE7, 8'h02};
  logic [7:0]  t_sc  [4] = '{8'hFF, 8'h08, 8'h3A, 8'h17};
  logic [1:0]  t_st  [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  always #5 aclk = ~aclk;
  dcp_sense_model sm (.aclk(aclk), .level_mv(lvl), .sense_mv(sense_mv));
  dcp_protect #(.OC_MS_CYCLES(32'h0000_000A), .SC_US_CYCLES(32'h0000_0002)) uut (
    .aclk(aclk), .aresetn(aresetn), .overcurrent_threshold_param(p_thr),
    .overcurrent_delay_param(p_dly), .short_circuit_discharge_param(p_sc),
    .sense_mv(sense_mv), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .oc_fault(oc_fault), .sc_fault(sc_fault), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    tally_and_finish;
  endtask
  task automatic rst;
    aresetn <= 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    rs = bresp;
    if (i == 50) hang();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (i == 50) hang();
    chk($sformatf("read %h", a), rdata, exp);
    chk($sformatf("resp %h", a), rresp, er);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (k = 0; k < 4; k++) begin
      p_thr <= t_thr[k];
      p_dly <= t_dly[k];
      p_sc <= t_sc[k];
      rst();
      rchk(8'h00, t_thr[k] & 8'h0F, 2'b00);
      rchk(8'h04, t_dly[k] & 8'h0F, 2'b00);
      rchk(8'h08, t_sc[k] & 8'hF7, 2'b00);
      wr(8'h0C, t_st[k]);
      rchk(8'h0C, t_st[k], 2'b00);
      e_oc = t_st[k][0] ? 25 + 5 * t_thr[k][3:0] : 50 + 10 * t_thr[k][3:0];
      e_sc = t_st[k][0] ? 50 + 25 * t_sc[k][2:0] : 100 + 50 * t_sc[k][2:0];
      e_om = 1 + 2 * t_dly[k][3:0];
      e_su = 61 * t_sc[k][7:4] * (t_st[k][1] ? 2 : 1);
      rchk(8'h1C, (e_sc << 16) | e_oc, 2'b00);
      rchk(8'h10, (e_su << 16) | e_om, 2'b00);
    end
    wr(8'h00, 32'h0000_000F);
    chk("ro write resp", rs, 2'b00);
    p_thr <= 8'h09;
    rchk(8'h00, 32'h0000_0000, 2'b00);
    rchk(8'h20, 32'h0000_0000, 2'b10);
    wr(8'h18, 32'h0000_0003);
    lvl <= 16'h0064;
    repeat (30) @(posedge aclk);
    chk("oc early", oc_fault, 1'b0);
    lvl <= 16'h0000;
    repeat (3) @(posedge aclk);
    lvl <= 16'h0064;
    repeat (30) @(posedge aclk);
    chk("oc restart", oc_fault, 1'b0);
    for (i = 0; i < 60 && oc_fault !== 1'b1; i++) @(posedge aclk);
    chk("oc trip", oc_fault, 1'b1);
    chk("sc below", sc_fault, 1'b0);
    lvl <= 16'h01F4;
    repeat (150) @(posedge aclk);
    chk("sc doubled", sc_fault, 1'b0);
    for (i = 0; i < 200 && sc_fault !== 1'b1; i++) @(posedge aclk);
    chk("sc trip", sc_fault, 1'b1);
    chk("irq on", irq, 1'b1);
    wr(8'h18, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk("irq masked", irq, 1'b0);
    wr(8'h18, 32'h0000_0003);
    rchk(8'h14, 32'h0000_000F, 2'b00);
    lvl <= 16'h0000;
    repeat (10) @(posedge aclk);
    rchk(8'h14, 32'h0000_0000, 2'b00);
    repeat (3) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
    tally_and_finish();
  end
endmodule // test_discharge_current_protection_cfg
bind dcp_protect dcp_protect_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .sense_mv(sense_mv), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .oc_fault(oc_fault), .sc_fault(sc_fault), .irq(irq));
`default_nettype wire
